// File: design/pbjmux_pkg.sv
// ****************************************************************
// Register map and field layout
// ****************************************************************
package pbjmux_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PORT_W = 8;

  // Byte offsets of the word registers on the APB bus
  localparam logic [7:0] OFF_PB_PINS = 8'h00;
  localparam logic [7:0] OFF_PB_LAT = 8'h04;
  localparam logic [7:0] OFF_PB_DIR = 8'h08;
  localparam logic [7:0] OFF_PJ_PINS = 8'h0c;
  localparam logic [7:0] OFF_PJ_LAT = 8'h10;
  localparam logic [7:0] OFF_PJ_DIR = 8'h14;
  localparam logic [7:0] OFF_PADCFG = 8'h18;
  localparam logic [7:0] OFF_CTRL = 8'h1c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h24;
  localparam logic [7:0] OFF_IRQ_EN = 8'h28;

  // Reset values
  localparam logic [7:0] RST_LAT = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_PADCFG = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h01;
  localparam logic [1:0] RST_IRQ = 2'h0;

  // Field positions
  localparam int CTRL_PU_DIS_N = 0;
  localparam int PADCFG_PJ_PU = 5;
  localparam int IRQ_W = 2;
  localparam int IRQ_CHG = 0;
  localparam int IRQ_EXT3 = 1;

  // Port B pin roles
  localparam int PB_CHAN2 = 3;
  localparam int PB_TMR = 5;
  localparam int PB_DBG_CLK = 6;
  localparam int PB_DBG_DAT = 7;
  localparam int PB_CHG_LO = 4;
  localparam int CHG_W = 4;

  // Implemented bits of the pad configuration register
  localparam logic [7:0] PADCFG_MASK = 8'he6;

endpackage : pbjmux_pkg

// File: design/pbjmux_chg_det.sv
`timescale 1ns/1ps
// ****************************************************************
// Pin-change compare against the last value read
// ****************************************************************
module pbjmux_chg_det #(
  parameter int W = 4
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic [W-1:0] pins, // Live pin levels
  input wire logic [W-1:0] as_input, // Pin configured as input
  input wire logic read_pulse, // Port register read completes
  output logic change // Some input differs from snapshot
);

  logic [W-1:0] snap_q;
  logic [W-1:0] snap_d;

  // Snapshot refreshed only by a read; output pins never compare
  assign snap_d = read_pulse ? pins : snap_q;
  assign change = |((pins ^ snap_q) & as_input);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_q <= '0;
    end else begin
      snap_q <= snap_d;
    end
  end

endmodule : pbjmux_chg_det

// File: design/pbjmux_top.sv
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - A port B pin with direction 1 is an input read through the pin register, pulled up while the disable bit is 0.
// - Port B bit 3 as an input also feeds external interrupt channel 3.
// - Mapped capture/compare channel 2 drives bit 3 with direction 0 and takes its capture input with direction 1.
// - Enhanced PWM channel A overrides bit 3 and may float during a PWM shutdown.
// - Channel 2 uses bit 3 only when its pin-select bit is 0 and extended mode is active.
// - Port B bit 5 feeds the timer 3 clock and timer 1 gate whatever its direction.
// - With the serial debug function on, bit 7 is its two-way data line and bit 6 its clock input.
// - Functions marked don't care ignore the direction bit and override it.
// - With the memory interface on, port J bits 0, 1 and 5 carry latch enable, output enable and chip enable.
// - With the memory interface on, port J bits 2 and 3 carry the low and high write strobes.
// - With the memory interface on, port J bits 4, 6 and 7 carry byte address 0 and the byte selects.
// - On the reduced-pin variant the port J registers and its pull-up control read as zero.
module pbjmux_top #(
  parameter bit REDUCED_PKG = 1'b0
) (
  input wire logic pclk, // System clock, 250 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic [7:0] pb_in, // Port B pin levels
  output logic [7:0] pb_out, // Port B pin drive value
  output logic [7:0] pb_oe, // Port B drive enable
  output logic [7:0] pb_pullup, // Port B weak pull-up on
  input wire logic [7:0] pj_in, // Port J pin levels
  output logic [7:0] pj_out, // Port J pin drive value
  output logic [7:0] pj_oe, // Port J drive enable
  output logic [7:0] pj_pullup, // Port J weak pull-up on
  input wire logic chan2_pin_select, // Config bit, 0 picks bit 3
  input wire logic ext_mode, // Extended controller mode
  input wire logic chan2_out_en, // Compare/PWM output active
  input wire logic chan2_out, // Compare/PWM output level
  output logic chan2_capture_in, // Capture input to channel 2
  input wire logic pwm2a_en, // Enhanced PWM channel A active
  input wire logic pwm2a_out, // Enhanced PWM channel A level
  input wire logic pwm2a_shutdown_tri, // Float pin during shutdown
  output logic ext_irq3_in, // External interrupt 3 input
  output logic timer3_clk_in, // Timer 3 external clock
  output logic timer1_gate_in, // Timer 1 gate
  input wire logic debug_active, // Serial debug function on
  input wire logic debug_data_oe, // Debug wants to drive data
  input wire logic debug_data_out, // Debug data to pin
  output logic debug_serial_clk, // Debug clock from pin
  output logic debug_serial_data, // Debug data from pin
  input wire logic emi_active, // External memory bus on
  input wire logic emi_ale, // Address latch enable
  input wire logic emi_oe_n, // Output enable, active low
  input wire logic write_low_strobe, // Low byte write strobe
  input wire logic write_high_strobe, // High byte write strobe
  input wire logic byte_addr_bit0, // Byte address 0
  input wire logic emi_ce_n, // Chip enable, active low
  input wire logic low_byte_select, // Lower byte enable
  input wire logic upper_byte_select, // Upper byte enable
  output logic irq // Level interrupt
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  logic setup_ph;
  logic wr_acc;
  logic rd_acc;
  logic hit_pb_pins;
  logic hit_pb_lat;
  logic hit_pb_dir;
  logic hit_pj_pins;
  logic hit_pj_lat;
  logic hit_pj_dir;
  logic hit_padcfg;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_clr;
  logic hit_en;
  logic hit_any;

  // Zero-wait slave: data registered in setup, ready in access
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign hit_pb_pins = addr_hit(paddr, pbjmux_pkg::OFF_PB_PINS);
  assign hit_pb_lat = addr_hit(paddr, pbjmux_pkg::OFF_PB_LAT);
  assign hit_pb_dir = addr_hit(paddr, pbjmux_pkg::OFF_PB_DIR);
  assign hit_pj_pins = addr_hit(paddr, pbjmux_pkg::OFF_PJ_PINS);
  assign hit_pj_lat = addr_hit(paddr, pbjmux_pkg::OFF_PJ_LAT);
  assign hit_pj_dir = addr_hit(paddr, pbjmux_pkg::OFF_PJ_DIR);
  assign hit_padcfg = addr_hit(paddr, pbjmux_pkg::OFF_PADCFG);
  assign hit_ctrl = addr_hit(paddr, pbjmux_pkg::OFF_CTRL);
  assign hit_stat = addr_hit(paddr, pbjmux_pkg::OFF_IRQ_STAT);
  assign hit_clr = addr_hit(paddr, pbjmux_pkg::OFF_IRQ_CLR);
  assign hit_en = addr_hit(paddr, pbjmux_pkg::OFF_IRQ_EN);
  assign hit_any = hit_pb_pins | hit_pb_lat | hit_pb_dir | hit_pj_pins | hit_pj_lat | hit_pj_dir
                 | hit_padcfg | hit_ctrl | hit_stat | hit_clr | hit_en;

  // ****************************************************************
  // Software registers
  // ****************************************************************

  logic [7:0] pb_lat_q;
  logic [7:0] pb_lat_d;
  logic [7:0] pb_dir_q;
  logic [7:0] pb_dir_d;
  logic [7:0] pj_lat_q;
  logic [7:0] pj_lat_d;
  logic [7:0] pj_dir_q;
  logic [7:0] pj_dir_d;
  logic [7:0] padcfg_q;
  logic [7:0] padcfg_d;
  logic weak_pullup_disable_n_q;
  logic weak_pullup_disable_n_d;
  logic [7:0] wbyte;

  // Writing a pin register lands in the latch, as on a real port
  assign wbyte = pwdata[7:0];
  assign pb_lat_d = (wr_acc & (hit_pb_lat | hit_pb_pins)) ? wbyte : pb_lat_q;
  assign pb_dir_d = (wr_acc & hit_pb_dir) ? wbyte : pb_dir_q;
  assign pj_lat_d = (wr_acc & (hit_pj_lat | hit_pj_pins)) ? wbyte : pj_lat_q;
  assign pj_dir_d = (wr_acc & hit_pj_dir) ? wbyte : pj_dir_q;
  assign padcfg_d = (wr_acc & hit_padcfg) ? (wbyte & pbjmux_pkg::PADCFG_MASK) : padcfg_q;
  assign weak_pullup_disable_n_d = (wr_acc & hit_ctrl) ? pwdata[pbjmux_pkg::CTRL_PU_DIS_N]
                                                       : weak_pullup_disable_n_q;

  // Register state, writes taken at the access edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_lat_q <= pbjmux_pkg::RST_LAT;
      pb_dir_q <= pbjmux_pkg::RST_DIR;
      pj_lat_q <= pbjmux_pkg::RST_LAT;
      pj_dir_q <= pbjmux_pkg::RST_DIR;
      padcfg_q <= pbjmux_pkg::RST_PADCFG;
      weak_pullup_disable_n_q <= pbjmux_pkg::RST_CTRL[pbjmux_pkg::CTRL_PU_DIS_N];
    end else begin
      pb_lat_q <= pb_lat_d;
      pb_dir_q <= pb_dir_d;
      pj_lat_q <= pj_lat_d;
      pj_dir_q <= pj_dir_d;
      padcfg_q <= padcfg_d;
      weak_pullup_disable_n_q <= weak_pullup_disable_n_d;
    end
  end

  // ****************************************************************
  // Port B pin functions
  // ****************************************************************

  logic chan2_mapped;
  logic chan2_drive;
  logic pwm2a_drive;
  logic pwm2a_float;
  logic [7:0] pb_is_in;
  logic [7:0] pb_out_base;
  logic [7:0] pb_oe_base;

  // Channel 2 reaches bit 3 only through the alternate mapping
  assign chan2_mapped = ~chan2_pin_select & ext_mode;
  assign chan2_drive = chan2_mapped & chan2_out_en & ~pb_dir_q[pbjmux_pkg::PB_CHAN2];
  assign pwm2a_drive = chan2_mapped & pwm2a_en & ~pb_dir_q[pbjmux_pkg::PB_CHAN2];
  assign pwm2a_float = pwm2a_drive & pwm2a_shutdown_tri;

  // Plain port behaviour before any override
  assign pb_is_in = pb_dir_q;
  assign pb_out_base = pb_lat_q;
  assign pb_oe_base = ~pb_dir_q;

  // Per-bit override, peripheral output first, then latch
  always_comb begin
    pb_out = pb_out_base;
    pb_oe = pb_oe_base;
    if (pwm2a_drive) begin
      pb_out[pbjmux_pkg::PB_CHAN2] = pwm2a_out;
      pb_oe[pbjmux_pkg::PB_CHAN2] = ~pwm2a_float;
    end else if (chan2_drive) begin
      pb_out[pbjmux_pkg::PB_CHAN2] = chan2_out;
    end
    if (debug_active) begin
      pb_oe[pbjmux_pkg::PB_DBG_CLK] = 1'b0;
      pb_out[pbjmux_pkg::PB_DBG_DAT] = debug_data_out;
      pb_oe[pbjmux_pkg::PB_DBG_DAT] = debug_data_oe;
    end
  end

  // Pull-up only on inputs; a driven pin never carries one
  assign pb_pullup = pb_is_in & ~pb_oe & {8{~weak_pullup_disable_n_q}};

  // Input taps toward peripherals
  assign ext_irq3_in = pb_in[pbjmux_pkg::PB_CHAN2] & pb_dir_q[pbjmux_pkg::PB_CHAN2];
  assign chan2_capture_in = pb_in[pbjmux_pkg::PB_CHAN2] & pb_dir_q[pbjmux_pkg::PB_CHAN2]
                          & chan2_mapped;
  assign timer3_clk_in = pb_in[pbjmux_pkg::PB_TMR];
  assign timer1_gate_in = pb_in[pbjmux_pkg::PB_TMR];
  assign debug_serial_clk = pb_in[pbjmux_pkg::PB_DBG_CLK] & debug_active;
  assign debug_serial_data = pb_in[pbjmux_pkg::PB_DBG_DAT] & debug_active;

  // ****************************************************************
  // Port J pin functions
  // ****************************************************************

  logic [7:0] emi_vec;
  logic [7:0] pj_lat_rd;
  logic [7:0] pj_dir_rd;
  logic [7:0] pj_pins_rd;
  logic [7:0] padcfg_rd;
  logic port_j_pullup_on;

  // Strobes in pin order, bit 0 upward
  assign emi_vec = {upper_byte_select, low_byte_select, emi_ce_n, byte_addr_bit0,
                    write_high_strobe, write_low_strobe, emi_oe_n, emi_ale};

  // Memory strobes beat the latch whatever the direction bits say
  assign pj_out = REDUCED_PKG ? 8'h00 : (emi_active ? emi_vec : pj_lat_q);
  assign pj_oe = REDUCED_PKG ? 8'h00 : (emi_active ? 8'hff : ~pj_dir_q);

  // Pin-poor variant: whole port and its pull-up bit vanish
  assign port_j_pullup_on = padcfg_q[pbjmux_pkg::PADCFG_PJ_PU] & ~REDUCED_PKG;
  assign pj_pullup = ~pj_oe & pj_dir_q & {8{port_j_pullup_on}};
  assign pj_lat_rd = REDUCED_PKG ? 8'h00 : pj_lat_q;
  assign pj_dir_rd = REDUCED_PKG ? 8'h00 : pj_dir_q;
  assign pj_pins_rd = REDUCED_PKG ? 8'h00 : pj_in;
  assign padcfg_rd = REDUCED_PKG ? (padcfg_q & ~(8'h01 << pbjmux_pkg::PADCFG_PJ_PU)) : padcfg_q;

  // ****************************************************************
  // Events and interrupt
  // ****************************************************************

  logic chg_now;
  logic pb_read;
  logic ext3_prev_q;
  logic ext3_rise;
  logic [1:0] ev;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_stat_d;
  logic [1:0] irq_en_q;
  logic [1:0] irq_en_d;
  logic [1:0] clr_bits;

  assign pb_read = rd_acc & hit_pb_pins;

  pbjmux_chg_det #(
    .W(pbjmux_pkg::CHG_W)
  ) u_chg (
    .pclk(pclk),
    .presetn(presetn),
    .pins(pb_in[pbjmux_pkg::PB_CHG_LO +: pbjmux_pkg::CHG_W]),
    .as_input(pb_dir_q[pbjmux_pkg::PB_CHG_LO +: pbjmux_pkg::CHG_W]),
    .read_pulse(pb_read),
    .change(chg_now)
  );

  // Set beats clear so a change in the clear cycle is kept
  assign ext3_rise = ext_irq3_in & ~ext3_prev_q;
  assign ev = {ext3_rise, chg_now};
  assign clr_bits = (wr_acc & hit_clr) ? pwdata[pbjmux_pkg::IRQ_W-1:0] : 2'h0;
  assign irq_stat_d = (irq_stat_q & ~clr_bits) | ev;
  assign irq_en_d = (wr_acc & hit_en) ? pwdata[pbjmux_pkg::IRQ_W-1:0] : irq_en_q;
  assign irq = |(irq_stat_q & irq_en_q);

  // Sticky status and enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= pbjmux_pkg::RST_IRQ;
      irq_en_q <= pbjmux_pkg::RST_IRQ;
      ext3_prev_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_en_q <= irq_en_d;
      ext3_prev_q <= ext_irq3_in;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************

  logic [7:0] rd_byte;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;

  // Address select, clear register reads as zero
  assign rd_byte = hit_pb_pins ? pb_in :
                   hit_pb_lat ? pb_lat_q :
                   hit_pb_dir ? pb_dir_q :
                   hit_pj_pins ? pj_pins_rd :
                   hit_pj_lat ? pj_lat_rd :
                   hit_pj_dir ? pj_dir_rd :
                   hit_padcfg ? padcfg_rd :
                   hit_ctrl ? {7'h00, weak_pullup_disable_n_q} :
                   hit_stat ? {6'h00, irq_stat_q} :
                   hit_en ? {6'h00, irq_en_q} : 8'h00;
  assign prdata_d = setup_ph ? {24'h000000, rd_byte} : prdata_q;
  assign pslverr_d = setup_ph ? ~hit_any : (penable ? pslverr_q : 1'b0);
  assign prdata = prdata_q;
  assign pslverr = pslverr_q & penable;

  // Read data captured in setup so it is steady through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

endmodule : pbjmux_top

// File: bench/pbjmux_checker.sv
`timescale 1ns/1ps
// ****************************************************************
// Pin function checks on the top-level ports
// ****************************************************************
module pbjmux_checker (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic [7:0] pb_in, // Pin levels
  input wire logic [7:0] pb_out, // Drive values
  input wire logic [7:0] pb_oe, // Drive enables
  input wire logic [7:0] pb_pullup, // Pull-ups
  input wire logic chan2_pin_select, // Map select
  input wire logic ext_mode, // Extended mode
  input wire logic chan2_out_en, // Compare active
  input wire logic chan2_out, // Compare level
  input wire logic chan2_capture_in, // Capture feed
  input wire logic pwm2a_en, // PWM A active
  input wire logic pwm2a_out, // PWM A level
  input wire logic pwm2a_shutdown_tri, // Float on shutdown
  input wire logic ext_irq3_in, // Interrupt 3 feed
  input wire logic timer3_clk_in, // Timer clock feed
  input wire logic timer1_gate_in, // Timer gate feed
  input wire logic debug_active, // Debug on
  input wire logic debug_data_oe, // Debug drives data
  input wire logic debug_data_out, // Debug data
  input wire logic debug_serial_clk // Debug clock feed
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Channel 2 owns bit 3 only in this mapping
  wire chan2_mapped = !chan2_pin_select && ext_mode;

  // A pull-up fighting the device's own drive would waste current
  pull_off_drive_a: assert property ((pb_pullup & pb_oe) == 8'h00) else $error("pull-up on driven pin");
  irq3_pin_a: assert property (ext_irq3_in |-> pb_in[3]) else $error("interrupt 3 without pin");
  chan2_drive_a: assert property (chan2_mapped && chan2_out_en && !pwm2a_en && pb_oe[3] |-> pb_out[3] == chan2_out)
    else $error("compare level lost");
  pwm_drive_a: assert property (chan2_mapped && pwm2a_en && pb_oe[3] |-> pb_out[3] == pwm2a_out)
    else $error("pwm level lost");
  pwm_float_a: assert property (chan2_mapped && pwm2a_en && pwm2a_shutdown_tri |-> !pb_oe[3])
    else $error("pin driven in shutdown");
  capt_map_a: assert property (!chan2_mapped |-> !chan2_capture_in) else $error("capture while unmapped");
  tmr_follow_a: assert property (timer3_clk_in == pb_in[5] && timer1_gate_in == pb_in[5])
    else $error("timer feeds stale");
  dbg_pins_a: assert property (debug_active |-> debug_serial_clk == pb_in[6] && !pb_oe[6] && pb_oe[7] == debug_data_oe)
    else $error("debug pins wrong");
  dbg_data_a: assert property (debug_active && debug_data_oe |-> pb_out[7] == debug_data_out)
    else $error("debug data wrong");
endmodule : pbjmux_checker

// File: bench/pbjmux_pin_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Board side of one 8-pin port
// ****************************************************************
module pbjmux_pin_model (
  input wire logic pclk, // Clock
  input wire logic [7:0] drv_out, // Device drive value
  input wire logic [7:0] drv_oe, // Device drive enable
  input wire logic [7:0] pull_on, // Weak pull-up on
  input wire logic [7:0] ext_en, // Outside driver on
  input wire logic [7:0] ext_val, // Outside driver value
  output logic [7:0] level // Resolved level
);
  logic [7:0] float_q = 8'h00;

  // An open pin wanders, so stale levels never look valid
  always_ff @(posedge pclk) begin
    float_q <= ~level;
  end

  // Device drive beats the weak outside driver, pull-up last
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level[i] = drv_oe[i] ? drv_out[i] : ext_en[i] ? ext_val[i] : pull_on[i] ? 1'b1 : float_q[i];
    end
  end
endmodule : pbjmux_pin_model

// File: bench/test_port_b_j_pin_function_mux.sv
`timescale 1ns/1ps
module test_port_b_j_pin_function_mux;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
  logic [7:0] paddr = 8'h00, pb_in, pb_out, pb_oe, pb_pullup, pj_in, pj_out, pj_oe, pj_pullup;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0] b_en = 8'hff, b_ext = 8'h00, j_ext = 8'h00;
  logic chan2_pin_select = 1'b1, ext_mode = 1'b0, chan2_out_en = 1'b0, chan2_out = 1'b0, chan2_capture_in;
  logic pwm2a_en = 1'b0, pwm2a_out = 1'b0, pwm2a_shutdown_tri = 1'b0, ext_irq3_in, timer3_clk_in, timer1_gate_in;
  logic debug_active = 1'b0, debug_data_oe = 1'b0, debug_data_out = 1'b0, debug_serial_clk, debug_serial_data;
  logic emi_active = 1'b0, emi_ale = 1'b0, emi_oe_n = 1'b0, write_low_strobe = 1'b0, write_high_strobe = 1'b0;
  logic byte_addr_bit0 = 1'b0, emi_ce_n = 1'b0, low_byte_select = 1'b0, upper_byte_select = 1'b0;
  int mismatches = 0, checked = 0;

  pbjmux_top uut (.*);
  pbjmux_pin_model pins_b (.pclk(pclk), .drv_out(pb_out), .drv_oe(pb_oe), .pull_on(pb_pullup), .ext_en(b_en),
    .ext_val(b_ext), .level(pb_in));
  pbjmux_pin_model pins_j (.pclk(pclk), .drv_out(pj_out), .drv_oe(pj_oe), .pull_on(pj_pullup), .ext_en(8'hff),
    .ext_val(j_ext), .level(pj_in));

  // ****************************************************************
  // Clock, bus and compare helpers
  // ****************************************************************
  initial begin
    forever #2 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Idle cycle after each transfer keeps psel from being assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, what);
    chk(32'(e), 32'h0, what);
  endtask : rd

  task automatic tick();
    @(posedge pclk);
  endtask : tick

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd(pbjmux_pkg::OFF_PB_LAT, 32'h00, "lat reset");
    rd(pbjmux_pkg::OFF_PB_DIR, 32'hff, "dir b reset");
    rd(pbjmux_pkg::OFF_PJ_DIR, 32'hff, "dir j reset");
    rd(pbjmux_pkg::OFF_CTRL, 32'h01, "ctrl reset");
    rd(pbjmux_pkg::OFF_IRQ_EN, 32'h00, "enable reset");
    wr(pbjmux_pkg::OFF_PADCFG, 32'hff);
    rd(pbjmux_pkg::OFF_PADCFG, 32'(pbjmux_pkg::PADCFG_MASK), "padcfg bits");
    rd(pbjmux_pkg::OFF_IRQ_CLR, 32'h00, "clear reads 0");
    apb(1'b0, 8'h3c, 32'h0, r, e);
    chk(32'(e), 32'h1, "unmapped err");
  endtask : t_regs

  task automatic t_port_b();
    wr(pbjmux_pkg::OFF_PB_PINS, 32'ha5);
    rd(pbjmux_pkg::OFF_PB_LAT, 32'ha5, "pins write to latch");
    wr(pbjmux_pkg::OFF_PB_DIR, 32'h00);
    chk(32'({pb_oe, pb_out}), 32'hffa5, "latch drive");
    wr(pbjmux_pkg::OFF_CTRL, 32'h00);
    wr(pbjmux_pkg::OFF_PB_DIR, 32'hf0);
    b_en <= 8'h00;
    tick();
    chk(32'(pb_pullup), 32'hf0, "pull-ups on inputs");
    rd(pbjmux_pkg::OFF_PB_PINS, 32'hf5, "pulled inputs read");
    b_en <= 8'hff;
  endtask : t_port_b

  task automatic t_change();
    logic [31:0] r;
    logic e;
    wr(pbjmux_pkg::OFF_PB_DIR, 32'hff);
    apb(1'b0, pbjmux_pkg::OFF_PB_PINS, 32'h0, r, e);
    wr(pbjmux_pkg::OFF_IRQ_CLR, 32'h3);
    wr(pbjmux_pkg::OFF_IRQ_EN, 32'h1);
    b_ext <= 8'h04;
    tick();
    rd(pbjmux_pkg::OFF_IRQ_STAT, 32'h0, "low pin ignored");
    b_ext <= 8'h14;
    tick();
    tick();
    chk(32'(irq), 32'h1, "change irq");
    rd(pbjmux_pkg::OFF_IRQ_STAT, 32'h1, "change flag");
    wr(pbjmux_pkg::OFF_IRQ_EN, 32'h0);
    chk(32'(irq), 32'h0, "irq masked");
    apb(1'b0, pbjmux_pkg::OFF_PB_PINS, 32'h0, r, e);
    wr(pbjmux_pkg::OFF_IRQ_CLR, 32'h1);
    rd(pbjmux_pkg::OFF_IRQ_STAT, 32'h0, "flag cleared after read");
    b_ext <= 8'h1c;
    tick();
    tick();
    chk(32'(ext_irq3_in), 32'h1, "ext_irq3_in feed");
    rd(pbjmux_pkg::OFF_IRQ_STAT, 32'h2, "ext_irq3_in flag");
    wr(pbjmux_pkg::OFF_PB_DIR, 32'hf7);
    chk(32'(ext_irq3_in), 32'h0, "ext_irq3_in needs input");
    wr(pbjmux_pkg::OFF_IRQ_EN, 32'h2);
    chk(32'(irq), 32'h1, "ext_irq3_in irq");
    wr(pbjmux_pkg::OFF_IRQ_CLR, 32'h2);
    chk(32'(irq), 32'h0, "ext_irq3_in cleared");
  endtask : t_change

  task automatic t_chan2();
    chan2_pin_select <= 1'b0;
    ext_mode <= 1'b1;
    chan2_out_en <= 1'b1;
    chan2_out <= 1'b1;
    wr(pbjmux_pkg::OFF_PB_LAT, 32'h00);
    chk(32'({pb_oe[3], pb_out[3]}), 32'h3, "compare drives");
    pwm2a_en <= 1'b1;
    tick();
    chk(32'({pb_oe[3], pb_out[3]}), 32'h2, "pwm wins");
    pwm2a_shutdown_tri <= 1'b1;
    tick();
    chk(32'(pb_oe[3]), 32'h0, "pwm shutdown floats");
    pwm2a_en <= 1'b0;
    ext_mode <= 1'b0;
    tick();
    chk(32'({pb_oe[3], pb_out[3]}), 32'h2, "unmapped uses latch");
    ext_mode <= 1'b1;
    wr(pbjmux_pkg::OFF_PB_DIR, 32'hff);
    chk(32'(chan2_capture_in), 32'h1, "capture feed");
    chan2_pin_select <= 1'b1;
    tick();
    chk(32'(chan2_capture_in), 32'h0, "capture off when remapped");
  endtask : t_chan2

  task automatic t_dbg();
    wr(pbjmux_pkg::OFF_PB_LAT, 32'h20);
    wr(pbjmux_pkg::OFF_PB_DIR, 32'hdf);
    chk(32'({timer3_clk_in, timer1_gate_in}), 32'h3, "timer feeds output");
    wr(pbjmux_pkg::OFF_PB_DIR, 32'hff);
    chk(32'({timer3_clk_in, timer1_gate_in}), 32'h0, "timer feeds input");
    debug_active <= 1'b1;
    debug_data_oe <= 1'b1;
    b_ext <= 8'h40;
    wr(pbjmux_pkg::OFF_PB_LAT, 32'hff);
    wr(pbjmux_pkg::OFF_PB_DIR, 32'h00);
    chk(32'({pb_oe[7:6], pb_out[7], debug_serial_clk}), 32'h9, "debug pins");
    debug_data_oe <= 1'b0;
    wr(pbjmux_pkg::OFF_PB_DIR, 32'h3f);
    b_ext <= 8'h80;
    tick();
    chk(32'({pb_oe[7], debug_serial_data}), 32'h1, "debug data in");
    debug_active <= 1'b0;
  endtask : t_dbg

  task automatic t_emi();
    wr(pbjmux_pkg::OFF_PJ_LAT, 32'h3c);
    wr(pbjmux_pkg::OFF_PJ_DIR, 32'h00);
    chk(32'({pj_oe, pj_out}), 32'hff3c, "j latch drive");
    emi_active <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      {upper_byte_select, low_byte_select, emi_ce_n, byte_addr_bit0, write_high_strobe, write_low_strobe, emi_oe_n,
        emi_ale} <= 8'h01 << i;
      wr(pbjmux_pkg::OFF_PJ_DIR, 32'(8'h01 << i));
      chk(32'({pj_oe, pj_out}), 32'({8'hff, 8'h01 << i}), "bus strobe");
    end
    emi_active <= 1'b0;
    j_ext <= 8'h5a;
    wr(pbjmux_pkg::OFF_PJ_DIR, 32'hff);
    chk(32'(pj_oe), 32'h0, "j inputs");
    chk(32'(pj_pullup), 32'hff, "j pull-ups on inputs");
    rd(pbjmux_pkg::OFF_PJ_PINS, 32'h5a, "j pins read");
  endtask : t_emi

  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic wrap_up();
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_port_b();
    t_change();
    t_chan2();
    t_dbg();
    t_emi();
    wrap_up();
  end

  // Whole run is under two hundred cycles; far beyond that means a hang
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    wrap_up();
  end
endmodule : test_port_b_j_pin_function_mux

bind pbjmux_top pbjmux_checker chk_i (.*);
